// *** caw_top.v ***
`timescale 1ns/1ns
`default_nettype none
`include "caw_defines.vh"

module caw_top #(
  parameter IS_64BIT = 1
) (
  // clock and reset
  input wire SYS_CLK_I,
  input wire RST_I,
  // apb
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output wire [31:0] PRDATA_O,
  output wire PREADY_O,
  output wire PSLVERR_O,
  // mode and extended-addressing bits from core
  input wire [1:0] MODE_I,
  input wire USER_EXT_ADDR_ENABLE_I,
  input wire SUPERVISOR_EXT_ADDR_ENABLE_I,
  input wire KERNEL_EXT_ADDR_ENABLE_I,
  // fetch
  input wire [63:0] FETCH_PC_I,
  output reg [63:0] FETCH_PC_O,
  // data access ahead of translation
  input wire [63:0] DATA_VADDR_I,
  output reg [63:0] DATA_VADDR_O,
  // control-transfer target
  input wire [63:0] BRANCH_TARGET_I,
  output reg [63:0] BRANCH_TARGET_O,
  // pc-relative calculation
  input wire [63:0] PCREL_RESULT_I,
  output reg [63:0] PCREL_RESULT_O,
  // page-table walker
  input wire [63:0] WALK_ADDR_I,
  output reg [63:0] WALK_ADDR_O
);

  wire [31:0] ctrl;
  wire [63:0] sw_addr;
  wire [63:0] sw_res;
  wire sw_wrapped;
  wire [63:0] w_fetch;
  wire [63:0] w_data;
  wire [63:0] w_branch;
  wire [63:0] w_pcrel;
  wire [63:0] w_walk;

  // ==========================================================
  // register slave; a software probe wraps through the ctrl mode and bits
  caw_apb u_apb (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .psel_i(PSEL_I),
    .penable_i(PENABLE_I),
    .pwrite_i(PWRITE_I),
    .paddr_i(PADDR_I),
    .pwdata_i(PWDATA_I),
    .prdata_o(PRDATA_O),
    .pready_o(PREADY_O),
    .pslverr_o(PSLVERR_O),
    .ctrl_o(ctrl),
    .addr_o(sw_addr),
    .res_i(sw_res),
    .wrapped_i(sw_wrapped)
  );

  caw_wrap #(.ADDR_W(64), .IS_64BIT(IS_64BIT)) u_probe (
    .addr_i(sw_addr),
    .mode_i(ctrl[`CAW_CTRL_MODE_HI:`CAW_CTRL_MODE_LO]),
    .user_ext_addr_enable_i(ctrl[`CAW_CTRL_UX]),
    .supervisor_ext_addr_enable_i(ctrl[`CAW_CTRL_SX]),
    .kernel_ext_addr_enable_i(ctrl[`CAW_CTRL_KX]),
    .addr_o(sw_res),
    .wrapped_o(sw_wrapped)
  );

  // ==========================================================
  // core paths, one wrapper each
  caw_wrap #(.ADDR_W(64), .IS_64BIT(IS_64BIT)) u_fetch (
    .addr_i(FETCH_PC_I),
    .mode_i(MODE_I),
    .user_ext_addr_enable_i(USER_EXT_ADDR_ENABLE_I),
    .supervisor_ext_addr_enable_i(SUPERVISOR_EXT_ADDR_ENABLE_I),
    .kernel_ext_addr_enable_i(KERNEL_EXT_ADDR_ENABLE_I),
    .addr_o(w_fetch),
    .wrapped_o()
  );

  caw_wrap #(.ADDR_W(64), .IS_64BIT(IS_64BIT)) u_data (
    .addr_i(DATA_VADDR_I),
    .mode_i(MODE_I),
    .user_ext_addr_enable_i(USER_EXT_ADDR_ENABLE_I),
    .supervisor_ext_addr_enable_i(SUPERVISOR_EXT_ADDR_ENABLE_I),
    .kernel_ext_addr_enable_i(KERNEL_EXT_ADDR_ENABLE_I),
    .addr_o(w_data),
    .wrapped_o()
  );

  caw_wrap #(.ADDR_W(64), .IS_64BIT(IS_64BIT)) u_branch (
    .addr_i(BRANCH_TARGET_I),
    .mode_i(MODE_I),
    .user_ext_addr_enable_i(USER_EXT_ADDR_ENABLE_I),
    .supervisor_ext_addr_enable_i(SUPERVISOR_EXT_ADDR_ENABLE_I),
    .kernel_ext_addr_enable_i(KERNEL_EXT_ADDR_ENABLE_I),
    .addr_o(w_branch),
    .wrapped_o()
  );

  caw_wrap #(.ADDR_W(64), .IS_64BIT(IS_64BIT)) u_pcrel (
    .addr_i(PCREL_RESULT_I),
    .mode_i(MODE_I),
    .user_ext_addr_enable_i(USER_EXT_ADDR_ENABLE_I),
    .supervisor_ext_addr_enable_i(SUPERVISOR_EXT_ADDR_ENABLE_I),
    .kernel_ext_addr_enable_i(KERNEL_EXT_ADDR_ENABLE_I),
    .addr_o(w_pcrel),
    .wrapped_o()
  );

  // walker always runs with kernel treatment
  caw_wrap #(.ADDR_W(64), .IS_64BIT(IS_64BIT)) u_walk (
    .addr_i(WALK_ADDR_I),
    .mode_i(`CAW_MODE_WALKER),
    .user_ext_addr_enable_i(USER_EXT_ADDR_ENABLE_I),
    .supervisor_ext_addr_enable_i(SUPERVISOR_EXT_ADDR_ENABLE_I),
    .kernel_ext_addr_enable_i(KERNEL_EXT_ADDR_ENABLE_I),
    .addr_o(w_walk),
    .wrapped_o()
  );

  // ==========================================================
  // outputs registered, one cycle after inputs
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      FETCH_PC_O <= 64'h0000_0000_0000_0000;
      DATA_VADDR_O <= 64'h0000_0000_0000_0000;
      BRANCH_TARGET_O <= 64'h0000_0000_0000_0000;
      PCREL_RESULT_O <= 64'h0000_0000_0000_0000;
      WALK_ADDR_O <= 64'h0000_0000_0000_0000;
    end else begin
      FETCH_PC_O <= w_fetch;
      DATA_VADDR_O <= w_data;
      BRANCH_TARGET_O <= w_branch;
      PCREL_RESULT_O <= w_pcrel;
      WALK_ADDR_O <= w_walk;
    end
  end

endmodule
`default_nettype wire

// *** caw_defines.vh ***
`ifndef CAW_DEFINES_VH
`define CAW_DEFINES_VH

// ==========================================================
// privilege mode encoding
`define CAW_MODE_USER 2'h0
`define CAW_MODE_SUPERVISOR 2'h1
`define CAW_MODE_KERNEL 2'h2
`define CAW_MODE_WALKER 2'h3

// ==========================================================
// address geometry
`define CAW_ADDR_W 64
`define CAW_WRAP_BIT 31
`define CAW_LOW_W 32

// ==========================================================
// register map
`define CAW_REG_CTRL 12'h000
`define CAW_REG_STATUS 12'h004
`define CAW_REG_ADDR_LO 12'h008
`define CAW_REG_ADDR_HI 12'h00C
`define CAW_REG_RES_LO 12'h010
`define CAW_REG_RES_HI 12'h014
`define CAW_CTRL_UX 0
`define CAW_CTRL_SX 1
`define CAW_CTRL_KX 2
`define CAW_CTRL_MODE_LO 4
`define CAW_CTRL_MODE_HI 5
`define CAW_CTRL_RESET 32'h0000_0000

`endif

// *** caw_wrap.v ***
`timescale 1ns/1ns
`default_nettype none
`include "caw_defines.vh"

module caw_wrap #(
  parameter ADDR_W = 64,
  parameter IS_64BIT = 1
) (
  // address and mode
  input wire [ADDR_W-1:0] addr_i,
  input wire [1:0] mode_i,
  input wire user_ext_addr_enable_i,
  input wire supervisor_ext_addr_enable_i,
  input wire kernel_ext_addr_enable_i,
  // result
  output reg [ADDR_W-1:0] addr_o,
  output reg wrapped_o
);

  always @* begin
    wrapped_o = 1'b0;
    if (IS_64BIT != 0) begin
      case (mode_i)
        `CAW_MODE_USER: wrapped_o = ~user_ext_addr_enable_i;
        `CAW_MODE_SUPERVISOR: wrapped_o = ~supervisor_ext_addr_enable_i;
        `CAW_MODE_KERNEL: wrapped_o = ~kernel_ext_addr_enable_i;
        `CAW_MODE_WALKER: wrapped_o = ~kernel_ext_addr_enable_i;
        default: wrapped_o = 1'b0;
      endcase
    end
    // upper half replaced by bit 31, dropping any carry out of the low word
    if (wrapped_o) begin
      addr_o = {{(ADDR_W-32){addr_i[`CAW_WRAP_BIT]}}, addr_i[31:0]};
    end else begin
      addr_o = addr_i;
    end
  end

endmodule
`default_nettype wire

// *** caw_apb.v ***
`timescale 1ns/1ns
`default_nettype none
`include "caw_defines.vh"

module caw_apb (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // apb
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // register state
  output reg [31:0] ctrl_o,
  output reg [63:0] addr_o,
  input wire [63:0] res_i,
  input wire wrapped_i
);

  wire access = psel_i & penable_i & ~pready_o;
  reg [31:0] next_rdata;
  reg next_err;

  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr_i)
      `CAW_REG_CTRL: next_rdata = ctrl_o;
      `CAW_REG_STATUS: next_rdata = {{31{1'b0}}, wrapped_i};
      `CAW_REG_ADDR_LO: next_rdata = addr_o[31:0];
      `CAW_REG_ADDR_HI: next_rdata = addr_o[63:32];
      `CAW_REG_RES_LO: next_rdata = res_i[31:0];
      `CAW_REG_RES_HI: next_rdata = res_i[63:32];
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      ctrl_o <= `CAW_CTRL_RESET;
      addr_o <= 64'h0000_0000_0000_0000;
    end else begin
      pready_o <= access;
      pslverr_o <= access & next_err;
      prdata_o <= (access & ~pwrite_i) ? next_rdata : 32'h0000_0000;
      // a write lands on the edge that completes the transfer
      if (psel_i & penable_i & pready_o & pwrite_i) begin
        case (paddr_i)
          `CAW_REG_CTRL: ctrl_o <= pwdata_i & 32'h0000_0037;
          `CAW_REG_ADDR_LO: addr_o[31:0] <= pwdata_i;
          `CAW_REG_ADDR_HI: addr_o[63:32] <= pwdata_i;
          default: ctrl_o <= ctrl_o;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** caw_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// core stub deriving the address of every path from one base address
module caw_core_model (
  // clock and request
  input wire logic clk_i,
  input wire logic [63:0] base_i,
  // addresses offered to the wrapper
  output var logic [63:0] fetch_o = 64'h0000,
  output var logic [63:0] data_o = 64'h0000,
  output var logic [63:0] branch_o = 64'h0000,
  output var logic [63:0] pcrel_o = 64'h0000,
  output var logic [63:0] walk_o = 64'h0000
);
  // offsets push low-half carries into bit 31 or bit 32
  always @(posedge clk_i) begin
    fetch_o <= base_i;
    data_o <= base_i + 64'h0010;
    branch_o <= base_i + 64'h0040;
    pcrel_o <= base_i - 64'h0010;
    walk_o <= base_i ^ 64'h8000_0000;
  end
endmodule
`default_nettype wire

// *** caw_top_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// wrap checks
module caw_top_asserts (
  // clock, reset and mode
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [1:0] MODE_I,
  input wire logic USER_EXT_ADDR_ENABLE_I,
  input wire logic SUPERVISOR_EXT_ADDR_ENABLE_I,
  input wire logic KERNEL_EXT_ADDR_ENABLE_I,
  // address paths
  input wire logic [63:0] FETCH_PC_I,
  input wire logic [63:0] FETCH_PC_O,
  input wire logic [63:0] DATA_VADDR_I,
  input wire logic [63:0] DATA_VADDR_O,
  input wire logic [63:0] BRANCH_TARGET_I,
  input wire logic [63:0] BRANCH_TARGET_O,
  input wire logic [63:0] PCREL_RESULT_I,
  input wire logic [63:0] PCREL_RESULT_O,
  input wire logic [63:0] WALK_ADDR_I,
  input wire logic [63:0] WALK_ADDR_O
);
  wire u = USER_EXT_ADDR_ENABLE_I;
  wire s = SUPERVISOR_EXT_ADDR_ENABLE_I;
  wire k = KERNEL_EXT_ADDR_ENABLE_I;
  wire en = (MODE_I == 2'h0 && !u) || (MODE_I == 2'h1 && !s) || (MODE_I[1] && !k);
  // low on the first edge after reset, while outputs still hold zeros
  logic ok;
  always @(posedge SYS_CLK_I or posedge RST_I) ok <= !RST_I;
  function automatic logic [63:0] wr(input logic [63:0] a, input logic w);
    return w ? {{32{a[31]}}, a[31:0]} : a;
  endfunction
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  property p_user; ok && $past(MODE_I) == 2'h0 |-> FETCH_PC_O == wr($past(FETCH_PC_I), !$past(u)); endproperty
  a_user: assert property (p_user) else $error("fetch wrap wrong in user mode");
  property p_sup; ok && $past(MODE_I) == 2'h1 |-> DATA_VADDR_O == wr($past(DATA_VADDR_I), !$past(s)); endproperty
  a_sup: assert property (p_sup) else $error("data wrap wrong in supervisor mode");
  property p_kern; ok && $past(MODE_I) == 2'h2 |-> BRANCH_TARGET_O == wr($past(BRANCH_TARGET_I), !$past(k)); endproperty
  a_kern: assert property (p_kern) else $error("target wrap wrong in kernel mode");
  property p_walk; ok |-> WALK_ADDR_O == wr($past(WALK_ADDR_I), !$past(k)); endproperty
  a_walk: assert property (p_walk) else $error("walker address wrap wrong");
  property p_carry; ok && $past(en) |-> PCREL_RESULT_O[63:32] == {32{PCREL_RESULT_O[31]}}; endproperty
  a_carry: assert property (p_carry) else $error("upper half not copies of bit 31");
  property p_data; ok |-> DATA_VADDR_O == wr($past(DATA_VADDR_I), $past(en)); endproperty
  a_data: assert property (p_data) else $error("data address wrap wrong");
  property p_branch; ok |-> BRANCH_TARGET_O == wr($past(BRANCH_TARGET_I), $past(en)); endproperty
  a_branch: assert property (p_branch) else $error("branch target wrap wrong");
  property p_pcrel; ok |-> PCREL_RESULT_O == wr($past(PCREL_RESULT_I), $past(en)); endproperty
  a_pcrel: assert property (p_pcrel) else $error("pc-relative result wrap wrong");
  property p_fetch; ok |-> FETCH_PC_O == wr($past(FETCH_PC_I), $past(en)); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrap wrong");
  c_wrap: cover property (ok && en);
  c_pass: cover property (ok && !en);
  c_walker: cover property (ok && MODE_I == 2'h3);
endmodule
bind caw_top caw_top_asserts i_caw_top_asserts (.*);
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [63:0] B0 = 64'h0000_0000_7fff_fff8;
  localparam logic [63:0] B1 = 64'h1234_5678_ffff_fff8;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, u = 0, s = 0, k = 0, e, pready, pslverr, er;
  logic [1:0] mode = 2'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [63:0] base = B1, fa, da, ba, pa, wa, fq, dq, bq, pq, wq;
  // each row: base select, kernel, supervisor and user bits, mode
  logic [5:0] rows [10] = '{6'h00, 6'h24, 6'h21, 6'h09, 6'h02, 6'h32, 6'h23, 6'h13, 6'h38, 6'h0e};
  int n_errors = 0, checks_done = 0, cyc = 0;
  always #50 clk = ~clk;
  caw_core_model i_caw_core_model (.clk_i(clk), .base_i(base), .fetch_o(fa), .data_o(da), .branch_o(ba),
    .pcrel_o(pa), .walk_o(wa));
  caw_top i_caw_top (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .MODE_I(mode), .USER_EXT_ADDR_ENABLE_I(u), .SUPERVISOR_EXT_ADDR_ENABLE_I(s), .KERNEL_EXT_ADDR_ENABLE_I(k),
    .FETCH_PC_I(fa), .FETCH_PC_O(fq), .DATA_VADDR_I(da), .DATA_VADDR_O(dq), .BRANCH_TARGET_I(ba),
    .BRANCH_TARGET_O(bq), .PCREL_RESULT_I(pa), .PCREL_RESULT_O(pq), .WALK_ADDR_I(wa), .WALK_ADDR_O(wq));
  function automatic logic [63:0] wr(input logic [63:0] a, input logic w);
    return w ? {{32{a[31]}}, a[31:0]} : a;
  endfunction
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task finish_test;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      finish_test;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    chk(fq, 64'h0000);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      {k, s, u} <= rows[i][4:2];
      mode <= rows[i][1:0];
      base <= rows[i][5] ? B1 : B0;
      repeat (2) @(posedge clk);
      #1;
      e = (mode == 2'h0 && !u) || (mode == 2'h1 && !s) || (mode[1] && !k);
      chk(fq, wr(fa, e));
      chk(dq, wr(da, e));
      chk(bq, wr(ba, e));
      chk(pq, wr(pa, e));
      chk(wq, wr(wa, !k));
      $display("row %0d done", i);
    end
    // probe through registers: reset control means user mode, wrapping
    apb(1'b1, 12'h008, 32'h8000_0000);
    apb(1'b1, 12'h00c, 32'h0000_0001);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk(rd, 32'hffff_ffff);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0024);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0024);
    apb(1'b0, 12'hffc, 32'h0000_0000);
    chk({er, rd}, 33'h1_0000_0000);
    $display("register test done");
    // reset in mid-run clears outputs and control
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(dq, 64'h0000_0000_0000_0000);
    chk(wq, 64'h0000_0000_0000_0000);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(dq, wr(da, e));
    chk(wq, wr(wa, !k));
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    $display("mid-run reset test done");
    finish_test;
  end
endmodule
`default_nettype wire
